// File: srb_bank_zero.v
/*
  Bank-zero special register file with the shared top-of-bank storage.
  Assumes the core presents one access per strobe and reads data one
  cycle later; peripherals behind the registers live elsewhere.
*/
`timescale 1ns/1ps
`default_nettype none
`include "srb_defs.vh"
// Notes on behaviour
// - Top sixteen bytes of every bank share storage.
// - Holding register feeds counter bits 12 to 8.
// - Core registers decode alike in every bank.
// - Unimplemented locations and bits read zero.
// - Without ports D and E, they read zero.
// - Pin or watchdog reset keeps unchanged bits.
// - Unknown bits free; condition bits follow cause.
module srb_bank_zero #(
  parameter HAS_PORT_DE = 1,
  parameter HAS_PSP     = 1
) (
  input  wire       core_clk,
  input  wire       nrst,
  input  wire       warm_rst_n,
  input  wire       cause_wdt,
  input  wire       cause_sleep,
  input  wire [8:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr_stb,
  input  wire       rd_stb,
  input  wire       pch_load,
  input  wire [7:0] pins_a,
  input  wire [7:0] pins_b,
  input  wire [7:0] pins_c,
  input  wire [7:0] pins_d,
  input  wire [7:0] pins_e,
  output reg  [7:0] rdata,
  output reg  [4:0] pc_upper_r,
  output reg  [7:0] lat_a_r,
  output reg  [7:0] lat_b_r,
  output reg  [7:0] lat_c_r,
  output reg  [7:0] lat_d_r,
  output reg  [7:0] lat_e_r,
  output reg  [1:0] bank_sel_r
);

  reg [7:0] sfr_r [0:31];
  reg [7:0] shared_r [0:15];
  reg [7:0] pa_s1_r, pa_s2_r, pb_s1_r, pb_s2_r, pc_s1_r, pc_s2_r;
  reg [7:0] pd_s1_r, pd_s2_r, pe_s1_r, pe_s2_r;
  reg       warm_s1_r, warm_s2_r, warm_d_r;
  reg       wdt_s1_r, wdt_s2_r, slp_s1_r, slp_s2_r;
  reg       por_done_r;
  reg [7:0] rd_nxt;
  reg [8:0] eff_addr;
  integer   i;

  // Implemented-bit mask for each bank-zero location.
  function [7:0] bit_mask;
    input [4:0] a;
    begin
      if (a == `SRB_A_INDIRECT_DATA_PORT) begin
        bit_mask = 8'h00;
      end else if (a == `SRB_A_PORT_A_PINS) begin
        bit_mask = `SRB_MASK_PORT_A_PINS;
      end else if (a == `SRB_A_PORT_D_PINS) begin
        bit_mask = (HAS_PORT_DE != 0) ? 8'hFF : 8'h00;
      end else if (a == `SRB_A_PORT_E_PINS) begin
        bit_mask = (HAS_PORT_DE != 0) ? `SRB_MASK_PORT_E_PINS : 8'h00;
      end else if (a == `SRB_A_PCHOLD) begin
        bit_mask = `SRB_MASK_PCHOLD;
      end else if (a == `SRB_A_PFLAG1) begin
        bit_mask = (HAS_PSP != 0) ? 8'hFF : `SRB_MASK_PFLAG1_NOPSP;
      end else if (a == `SRB_A_PFLAG2) begin
        bit_mask = `SRB_MASK_PFLAG2;
      end else if (a == `SRB_A_T1CTL) begin
        bit_mask = `SRB_MASK_T1CTL;
      end else if (a == `SRB_A_T2CTL) begin
        bit_mask = `SRB_MASK_T2CTL;
      end else if (a == `SRB_A_CCP1C || a == `SRB_A_CCP2C) begin
        bit_mask = `SRB_MASK_CCPC;
      end else if (a == `SRB_A_RXSTA) begin
        bit_mask = `SRB_MASK_RXSTA;
      end else if (a == `SRB_A_ADCTL) begin
        bit_mask = `SRB_MASK_ADCTL;
      end else begin
        bit_mask = 8'hFF;
      end
    end
  endfunction

  // True for locations decoded the same in all banks.
  function is_common;
    input [6:0] o;
    begin
      is_common = (o == 7'h00) || (o == 7'h02) || (o == 7'h03) ||
                  (o == 7'h04) || (o == 7'h0A) || (o == 7'h0B);
    end
  endfunction

  // Bits of each location that a pin or watchdog reset leaves alone.
  function [7:0] warm_keep;
    input [4:0] a;
    begin
      if (a == `SRB_A_INDIRECT_DATA_PORT) begin
        warm_keep = `SRB_KEEP_NONE;
      end else if (a == `SRB_A_PCLOW) begin
        warm_keep = `SRB_KEEP_NONE;
      end else if (a == `SRB_A_PCHOLD) begin
        warm_keep = `SRB_KEEP_NONE;
      end else if (a == `SRB_A_INTC) begin
        warm_keep = `SRB_KEEP_INTC;
      end else if (a == `SRB_A_PFLAG1) begin
        warm_keep = `SRB_KEEP_NONE;
      end else if (a == `SRB_A_PFLAG2) begin
        warm_keep = `SRB_KEEP_NONE;
      end else if (a == `SRB_A_TIMER_TWO_COUNT) begin
        warm_keep = `SRB_KEEP_NONE;
      end else if (a == `SRB_A_T2CTL) begin
        warm_keep = `SRB_KEEP_NONE;
      end else if (a == `SRB_A_SSCTL) begin
        warm_keep = `SRB_KEEP_NONE;
      end else if (a == `SRB_A_CCP1C) begin
        warm_keep = `SRB_KEEP_NONE;
      end else if (a == `SRB_A_RXSTA) begin
        warm_keep = `SRB_KEEP_RXSTA;
      end else if (a == `SRB_A_TXDAT) begin
        warm_keep = `SRB_KEEP_NONE;
      end else if (a == `SRB_A_RXDAT) begin
        warm_keep = `SRB_KEEP_NONE;
      end else if (a == `SRB_A_CCP2C) begin
        warm_keep = `SRB_KEEP_NONE;
      end else if (a == `SRB_A_ADCTL) begin
        warm_keep = `SRB_KEEP_NONE;
      end else begin
        warm_keep = `SRB_KEEP_ALL;
      end
    end
  endfunction

  // Indirect access takes its address from the pointer and the bank bit.
  always @* begin
    if (addr[6:0] == 7'h00) begin
      eff_addr = {sfr_r[`SRB_A_STAT][`SRB_STAT_IRP],
                  sfr_r[`SRB_A_PTR]};
    end else begin
      eff_addr = addr;
    end
  end

  wire [6:0] eoff   = eff_addr[6:0];
  wire       e_sfr0 = (eoff <= `SRB_SFR_TOP) &&
                      ((eff_addr[8:7] == 2'b00) || is_common(eoff));
  wire       e_shr  = (eoff >= `SRB_SHARED_BASE);
  wire [4:0] e_idx  = eoff[4:0];
  wire [3:0] s_idx  = eoff[3:0];
  wire       e_self = e_sfr0 && (e_idx == `SRB_A_INDIRECT_DATA_PORT);

  // Pin and reset-line synchronisers.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pa_s1_r   <= 8'h00;
      pa_s2_r   <= 8'h00;
      pb_s1_r   <= 8'h00;
      pb_s2_r   <= 8'h00;
      pc_s1_r   <= 8'h00;
      pc_s2_r   <= 8'h00;
      pd_s1_r   <= 8'h00;
      pd_s2_r   <= 8'h00;
      pe_s1_r   <= 8'h00;
      pe_s2_r   <= 8'h00;
      warm_s1_r <= 1'b0;
      warm_s2_r <= 1'b0;
      wdt_s1_r  <= 1'b0;
      wdt_s2_r  <= 1'b0;
      slp_s1_r  <= 1'b0;
      slp_s2_r  <= 1'b0;
    end else begin
      pa_s1_r   <= pins_a;
      pa_s2_r   <= pa_s1_r;
      pb_s1_r   <= pins_b;
      pb_s2_r   <= pb_s1_r;
      pc_s1_r   <= pins_c;
      pc_s2_r   <= pc_s1_r;
      pd_s1_r   <= pins_d;
      pd_s2_r   <= pd_s1_r;
      pe_s1_r   <= pins_e;
      pe_s2_r   <= pe_s1_r;
      warm_s1_r <= warm_rst_n;
      warm_s2_r <= warm_s1_r;
      wdt_s1_r  <= cause_wdt;
      wdt_s2_r  <= wdt_s1_r;
      slp_s1_r  <= cause_sleep;
      slp_s2_r  <= slp_s1_r;
    end
  end

  wire warm_hit = !warm_s2_r && warm_d_r;

  // Read data: port locations show the pins, others the stored value.
  always @* begin
    rd_nxt = 8'h00;
    if (e_self) begin
      rd_nxt = 8'h00;
    end else if (e_shr) begin
      rd_nxt = shared_r[s_idx];
    end else if (e_sfr0) begin
      if (e_idx == `SRB_A_PORT_A_PINS) begin
        rd_nxt = pa_s2_r;
      end else if (e_idx == `SRB_A_PORT_B_PINS) begin
        rd_nxt = pb_s2_r;
      end else if (e_idx == `SRB_A_PORT_C_PINS) begin
        rd_nxt = pc_s2_r;
      end else if (e_idx == `SRB_A_PORT_D_PINS) begin
        rd_nxt = pd_s2_r;
      end else if (e_idx == `SRB_A_PORT_E_PINS) begin
        rd_nxt = pe_s2_r;
      end else begin
        rd_nxt = sfr_r[e_idx];
      end
      rd_nxt = rd_nxt & bit_mask(e_idx);
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata      <= 8'h00;
      pc_upper_r <= 5'h00;
      warm_d_r   <= 1'b0;
      por_done_r <= 1'b0;
      bank_sel_r <= 2'b00;
      lat_a_r    <= 8'h00;
      lat_b_r    <= 8'h00;
      lat_c_r    <= 8'h00;
      lat_d_r    <= 8'h00;
      lat_e_r    <= 8'h00;
      for (i = 0; i < 32; i = i + 1) begin
        sfr_r[i] <= 8'h00;
      end
      for (i = 0; i < 16; i = i + 1) begin
        shared_r[i] <= 8'h00;
      end
      sfr_r[`SRB_A_STAT] <= 8'h18;
    end else begin
      warm_d_r   <= warm_s2_r;
      por_done_r <= 1'b1;
      rdata      <= rd_stb ? rd_nxt : 8'h00;
      bank_sel_r <= sfr_r[`SRB_A_STAT][6:5];
      if (pch_load) begin
        pc_upper_r <= sfr_r[`SRB_A_PCHOLD][4:0];
      end
      if (warm_hit) begin
        // Warm reset: reset-to-zero fields clear, unchanged ones stay.
        for (i = 0; i < 32; i = i + 1) begin
          sfr_r[i] <= sfr_r[i] & warm_keep(i[4:0]);
        end
        lat_a_r[5:0]         <= lat_a_r[5:0] & 6'h10;
        sfr_r[`SRB_A_STAT]   <= {3'b000, ~wdt_s2_r, ~slp_s2_r,
                                 sfr_r[`SRB_A_STAT][2:0]};
      end else if (wr_stb && !e_self) begin
        if (e_shr) begin
          shared_r[s_idx] <= wdata;
        end else if (e_sfr0 && e_idx != `SRB_A_RXDAT) begin
          if (e_idx == `SRB_A_STAT) begin
            // Timeout and power-down bits are not software writable.
            sfr_r[e_idx] <= (wdata & 8'hE7) |
                            (sfr_r[e_idx] & 8'h18);
          end else begin
            sfr_r[e_idx] <= wdata & bit_mask(e_idx);
          end
          if (e_idx == `SRB_A_PORT_A_PINS) begin
            lat_a_r <= wdata & `SRB_MASK_PORT_A_PINS;
          end else if (e_idx == `SRB_A_PORT_B_PINS) begin
            lat_b_r <= wdata;
          end else if (e_idx == `SRB_A_PORT_C_PINS) begin
            lat_c_r <= wdata;
          end else if (e_idx == `SRB_A_PORT_D_PINS) begin
            lat_d_r <= wdata & bit_mask(e_idx);
          end else if (e_idx == `SRB_A_PORT_E_PINS) begin
            lat_e_r <= wdata & bit_mask(e_idx);
          end
        end
      end
    end
  end

endmodule // srb_bank_zero
`default_nettype wire

// File: srb_defs.vh
/*
  Constants for the bank-zero special register block: offsets, field
  positions, warm-reset keep masks and bit masks.
  Assumes inclusion by bare name from the design file.
*/
`ifndef SRB_DEFS_VH
`define SRB_DEFS_VH

`define SRB_A_INDIRECT_DATA_PORT      5'h00
`define SRB_A_TIMER_ZERO_COUNT      5'h01
`define SRB_A_PCLOW     5'h02
`define SRB_A_STAT      5'h03
`define SRB_A_PTR       5'h04
`define SRB_A_PORT_A_PINS     5'h05
`define SRB_A_PORT_B_PINS     5'h06
`define SRB_A_PORT_C_PINS     5'h07
`define SRB_A_PORT_D_PINS     5'h08
`define SRB_A_PORT_E_PINS     5'h09
`define SRB_A_PCHOLD    5'h0A
`define SRB_A_INTC      5'h0B
`define SRB_A_PFLAG1    5'h0C
`define SRB_A_PFLAG2    5'h0D
`define SRB_A_TIMER_ONE_LOW     5'h0E
`define SRB_A_TIMER_ONE_HIGH     5'h0F
`define SRB_A_T1CTL     5'h10
`define SRB_A_TIMER_TWO_COUNT      5'h11
`define SRB_A_T2CTL     5'h12
`define SRB_A_SSBUF     5'h13
`define SRB_A_SSCTL     5'h14
`define SRB_A_CCP1L     5'h15
`define SRB_A_CCP1H     5'h16
`define SRB_A_CCP1C     5'h17
`define SRB_A_RXSTA     5'h18
`define SRB_A_TXDAT     5'h19
`define SRB_A_RXDAT     5'h1A
`define SRB_A_CCP2L     5'h1B
`define SRB_A_CCP2H     5'h1C
`define SRB_A_CCP2C     5'h1D
`define SRB_A_CONVERTER_RESULT     5'h1E
`define SRB_A_ADCTL     5'h1F

`define SRB_SHARED_BASE 7'h70
`define SRB_SFR_TOP     7'h1F
`define SRB_STAT_BANK_LO 5
`define SRB_STAT_TO     4
`define SRB_STAT_PD     3
`define SRB_STAT_IRP    7

`define SRB_MASK_PORT_A_PINS  8'h3F
`define SRB_MASK_PORT_E_PINS  8'h07
`define SRB_MASK_PCHOLD 8'h1F
`define SRB_MASK_PFLAG2 8'h01
`define SRB_MASK_T1CTL  8'h3F
`define SRB_MASK_T2CTL  8'h7F
`define SRB_MASK_CCPC   8'h3F
`define SRB_MASK_RXSTA  8'hF7
`define SRB_MASK_ADCTL  8'hFD
`define SRB_MASK_PFLAG1_NOPSP 8'h7F

`define SRB_KEEP_INTC   8'h01
`define SRB_KEEP_RXSTA  8'h01
`define SRB_KEEP_NONE   8'h00
`define SRB_KEEP_ALL    8'hFF

`endif

// File: srb_bank_zero_properties.sv
/* Port checker for the bank-zero register block.
   Assumes one clock, strobes as the core drives them. */
`timescale 1ns/1ps
`default_nettype none
module srb_bank_zero_props #(parameter HAS_PORT_DE = 1) (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       warm_rst_n,
  input wire logic [8:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic       pch_load,
  input wire logic [7:0] rdata,
  input wire logic [4:0] pc_upper_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire [6:0] off = addr[6:0];
  wire       b0 = addr[8:7] == 2'h0;
  wire       core_off = off == 7'h00 || off == 7'h02 || off == 7'h03 ||
                        off == 7'h04 || off == 7'h0A || off == 7'h0B;
  sequence s_top_wr; wr_stb && off[6:4] == 3'h7; endsequence
  sequence s_top_rd; rd_stb && off == $past(off); endsequence
  sequence s_stat_wr; wr_stb && off == 7'h03; endsequence
  sequence s_stat_rd; rd_stb && off == 7'h03; endsequence
  sequence s_hold_wr; wr_stb && off == 7'h0A; endsequence
  sequence s_load; pch_load && !wr_stb; endsequence
  property p_rd_idle; !rd_stb |=> rdata == 8'h00; endproperty
  property p_shared;
    s_top_wr ##1 s_top_rd |=> rdata == $past(wdata, 2);
  endproperty
  property p_bank_gap;
    rd_stb && !b0 && off < 7'h20 && !core_off |=> rdata == 8'h00;
  endproperty
  property p_stat_any;
    s_stat_wr ##1 s_stat_rd |=> rdata[7:5] == $past(wdata[7:5], 2) &&
      rdata[2:0] == $past(wdata[2:0], 2);
  endproperty
  property p_pch_load;
    s_hold_wr ##1 s_load |=> pc_upper_r == $past(wdata[4:0], 2);
  endproperty
  property p_pch_keep;
    disable iff (!nrst || !warm_rst_n) !pch_load |=> $stable(pc_upper_r);
  endproperty
  property p_port_a_pins; rd_stb && b0 && off == 7'h05 |=> rdata[7:6] == 2'h0;
  endproperty
  property p_pflag2; rd_stb && b0 && off == 7'h0D |=> rdata[7:1] == 7'h00;
  endproperty
  property p_port_de;
    HAS_PORT_DE == 0 && rd_stb && b0 && (off == 7'h08 || off == 7'h09)
      |=> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  a_shared: assert property (p_shared)
    else $error("shared byte mismatch");
  a_bank_gap: assert property (p_bank_gap)
    else $error("bank gap not zero");
  a_stat_any: assert property (p_stat_any)
    else $error("status readback mismatch");
  a_pch_load: assert property (p_pch_load)
    else $error("upper counter load mismatch");
  a_pch_keep: assert property (p_pch_keep)
    else $error("upper counter moved");
  a_port_a_pins: assert property (p_port_a_pins)
    else $error("port a top bits set");
  a_pflag2: assert property (p_pflag2)
    else $error("flag two top bits set");
  a_port_de: assert property (p_port_de)
    else $error("absent port not zero");
endmodule // srb_bank_zero_props
bind srb_bank_zero srb_bank_zero_props #(.HAS_PORT_DE(HAS_PORT_DE)) u_props (
  .core_clk, .nrst, .warm_rst_n, .addr, .wdata, .wr_stb, .rd_stb,
  .pch_load, .rdata, .pc_upper_r);
`default_nettype wire

// File: srb_bank_zero_test.sv
/* Self-checking bench for the bank-zero register block.
   Assumes the variant without ports D, E and the parallel port. */
`timescale 1ns/1ps
`default_nettype none
module srb_bank_zero_test;
  logic       core_clk = 1'b0;
  logic       nrst = 1'b0;
  logic       warm_rst_n = 1'b1;
  logic       cause_wdt = 1'b0;
  logic [8:0] addr = 9'h000;
  logic [7:0] wdata = 8'h00;
  logic       wr_stb = 1'b0;
  logic       rd_stb = 1'b0;
  logic       pch_load = 1'b0;
  logic       cause_sleep = 1'b0;
  logic [7:0] pins_a = 8'hFF;
  logic [7:0] pins_c = 8'h5A;
  wire  [7:0] rdata;
  wire  [4:0] pc_upper_r;
  wire  [7:0] lat_a_r;
  wire  [7:0] lat_b_r;
  wire  [7:0] lat_c_r;
  wire  [7:0] lat_d_r;
  wire  [7:0] lat_e_r;
  wire  [1:0] bank_sel_r;
  int         error_cnt = 0;
  int         checks_done = 0;
  always #5 core_clk = ~core_clk;
  srb_bank_zero #(.HAS_PORT_DE(0), .HAS_PSP(0)) u_srb_bank_zero (
    .core_clk(core_clk), .nrst(nrst), .warm_rst_n(warm_rst_n),
    .cause_wdt(cause_wdt), .cause_sleep(cause_sleep), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .pch_load(pch_load),
    .pins_a(pins_a), .pins_b(8'h00), .pins_c(pins_c), .pins_d(8'hFF),
    .pins_e(8'h00), .rdata(rdata), .pc_upper_r(pc_upper_r),
    .lat_a_r(lat_a_r), .lat_b_r(lat_b_r), .lat_c_r(lat_c_r),
    .lat_d_r(lat_d_r), .lat_e_r(lat_e_r), .bank_sel_r(bank_sel_r));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a; wdata <= d; wr_stb <= 1'b1; rd_stb <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    addr <= a; rd_stb <= 1'b1; wr_stb <= 1'b0;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    rd(9'h003, 8'h18);
    wr(9'h175, 8'hA5);
    rd(9'h075, 8'hA5);
    rd(9'h1F5, 8'hA5);
    wr(9'h103, 8'h05);
    rd(9'h003, 8'h1D);
    wr(9'h003, 8'h65);
    rd(9'h003, 8'h7D);
    chk({6'h00, bank_sel_r}, 8'h03);
    wr(9'h084, 8'h76);
    wr(9'h100, 8'h3C);
    rd(9'h076, 8'h3C);
    rd(9'h180, 8'h3C);
    $display("test shared and indirect done");
    wr(9'h01A, 8'hFF);
    rd(9'h01A, 8'h00);
    wr(9'h00D, 8'hFF);
    rd(9'h00D, 8'h01);
    wr(9'h00C, 8'h7F);
    rd(9'h00C, 8'h7F);
    rd(9'h085, 8'h00);
    rd(9'h005, 8'h3F);
    rd(9'h007, 8'h5A);
    @(posedge core_clk);
    pins_c <= 8'hA3;
    repeat (2) @(posedge core_clk);
    rd(9'h007, 8'hA3);
    wr(9'h009, 8'h07);
    rd(9'h009, 8'h00);
    wr(9'h005, 8'hFF);
    wr(9'h006, 8'hC3);
    wr(9'h007, 8'h5A);
    wr(9'h008, 8'hFF);
    rd(9'h008, 8'h00);
    chk(lat_a_r, 8'h3F);
    chk(lat_b_r, 8'hC3);
    chk(lat_c_r, 8'h5A);
    chk(lat_d_r, 8'h00);
    chk(lat_e_r, 8'h00);
    $display("test unimplemented done");
    wr(9'h08A, 8'hFF);
    @(posedge core_clk);
    wr_stb <= 1'b0; pch_load <= 1'b1;
    @(posedge core_clk);
    pch_load <= 1'b0;
    #1 chk({3'h0, pc_upper_r}, 8'h1F);
    rd(9'h10A, 8'h1F);
    wr(9'h00B, 8'hFF);
    $display("test holding done");
    @(posedge core_clk);
    wr_stb <= 1'b0; warm_rst_n <= 1'b0; cause_wdt <= 1'b1;
    cause_sleep <= 1'b1;
    repeat (6) @(posedge core_clk);
    warm_rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(9'h004, 8'h76);
    rd(9'h075, 8'hA5);
    rd(9'h00A, 8'h00);
    rd(9'h00B, 8'h01);
    rd(9'h003, 8'h05);
    chk(lat_a_r, 8'h10);
    chk(lat_b_r, 8'hC3);
    chk({6'h00, bank_sel_r}, 8'h00);
    $display("test warm reset done");
    stop_test();
  end
endmodule // srb_bank_zero_test
`default_nettype wire
